/* File: hdl/exc_pkg.sv */
// Constants and types shared by the exception and reset sequencing unit
package exc_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int unsigned WORD_W  = 32;
	localparam int unsigned VEC_W   = 8;
	localparam int unsigned LEVEL_W = 4;

	// ----------------------------------------
	// Vector numbers
	// ----------------------------------------
	localparam logic [7:0] VEC_POR_PC      = 8'h00;
	localparam logic [7:0] VEC_POR_SP      = 8'h01;
	localparam logic [7:0] VEC_MAN_PC      = 8'h02;
	localparam logic [7:0] VEC_MAN_SP      = 8'h03;
	localparam logic [7:0] VEC_ILLEGAL     = 8'h04;
	localparam logic [7:0] VEC_SLOT_ILL    = 8'h06;
	localparam logic [7:0] VEC_CPU_ADDR    = 8'h09;
	localparam logic [7:0] VEC_DMA_ADDR    = 8'h0A;
	localparam logic [7:0] VEC_NMI         = 8'h0B;
	localparam logic [7:0] VEC_BREAK       = 8'h0C;
	localparam logic [7:0] VEC_DEBUG       = 8'h0E;
	localparam logic [7:0] VEC_TRAP_BASE   = 8'h20;
	localparam logic [7:0] VEC_TRAP_MASK   = 8'h1F;
	localparam logic [7:0] VEC_IRQ_BASE    = 8'h40;
	localparam logic [7:0] VEC_PERIPH_BASE = 8'h48;

	// ----------------------------------------
	// Reset values and field layout
	// ----------------------------------------
	localparam logic [31:0] VBR_RESET      = 32'h0000_0000;
	localparam logic [3:0]  MASK_RESET     = 4'hF;
	localparam logic [31:0] STATUS_RESET   = 32'h0000_00F0;
	localparam int unsigned MASK_LSB       = 4;
	localparam logic [31:0] STACK_STEP     = 32'h0000_0004;
	localparam logic [1:0]  VEC_SHIFT_ZERO = 2'h0;

	// ----------------------------------------
	// Exception kinds
	// ----------------------------------------
	typedef enum logic [1:0] {
		KIND_ADDR  = 2'h0,
		KIND_INTR  = 2'h1,
		KIND_INSTR = 2'h2
	} exc_kind_t;

	// ----------------------------------------
	// Sequencer states, one-hot
	// ----------------------------------------
	typedef enum logic [8:0] {
		ST_RUN       = 9'h001,
		ST_POR_HOLD  = 9'h002,
		ST_MAN_WAIT  = 9'h004,
		ST_MAN_HOLD  = 9'h008,
		ST_FETCH_PC  = 9'h010,
		ST_FETCH_SP  = 9'h020,
		ST_PUSH_SR   = 9'h040,
		ST_PUSH_PC   = 9'h080,
		ST_FETCH_VEC = 9'h100
	} seq_state_t;
endpackage

/* File: hdl/exc_vec_addr.sv */
// Vector table address former
`timescale 1ns/1ps
`default_nettype none
module exc_vec_addr
	import exc_pkg::*;
(
	input  wire logic [VEC_W-1:0]  vector,
	input  wire logic              is_reset,
	input  wire logic [WORD_W-1:0] vector_base_reg,
	output logic      [WORD_W-1:0] table_addr
);
	// ----------------------------------------
	// Offset is vector times four; base added except for resets
	// ----------------------------------------
	logic [WORD_W-1:0] offset;
	assign offset     = {{(WORD_W-VEC_W-2){1'b0}}, vector, VEC_SHIFT_ZERO};
	assign table_addr = is_reset ? offset : vector_base_reg + offset;
endmodule
`default_nettype wire

/* File: hdl/exc_source_prio.sv */
// Fixed-priority selector of pending non-reset exceptions
`timescale 1ns/1ps
`default_nettype none
module exc_source_prio
	import exc_pkg::*;
(
	input  wire logic               addr_err_req,
	input  wire logic [VEC_W-1:0]   addr_err_vec,
	input  wire logic               intr_req,
	input  wire logic [VEC_W-1:0]   intr_vec,
	input  wire logic               instr_req,
	input  wire logic [VEC_W-1:0]   instr_vec,
	output logic                    any_req,
	output exc_kind_t               kind,
	output logic      [VEC_W-1:0]   vector
);
	// ----------------------------------------
	// Address errors before interrupts before instructions
	// ----------------------------------------
	always_comb
	begin
		any_req = addr_err_req | intr_req | instr_req;
		kind    = KIND_INSTR;
		vector  = instr_vec;
		if (addr_err_req)
		begin
			kind   = KIND_ADDR;
			vector = addr_err_vec;
		end
		else if (intr_req)
		begin
			kind   = KIND_INTR;
			vector = intr_vec;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/exc_reset_unit.sv */
// Exception entry and reset sequencing unit
// Contract
// - Push status word then instruction pointer on stack at general register fifteen.
// - Interrupts load accepted level into mask; other exceptions keep it.
// - After saving, fetch routine address from vector table and jump there.
// - Power-on uses vectors 0 and 1; manual reset uses 2 and 3.
// - Vectors 4, 6, 9, 10 for illegal, slot illegal, address errors.
// - Vectors 11, 12, 14 for nonmaskable, breakpoint and debug interrupts.
// - Trap vectors 32-63, external lines 64-71, peripherals 72-255.
// - Table address is vector times four, plus base unless a reset.
// - Resets beat all other sources; two reset types, both init CPU.
// - Power-on inits CPU, controller, peripherals; manual inits CPU and controller.
// - On power-on pin release, fetch pointer then stack pointer, then run.
// - Power-on processing clears vector base and sets mask to all ones.
// - Watchdog overflow causes power-on reset sparing pin and port registers.
// - Pin reset beats coincident watchdog reset and clears overflow flag.
// - Power-on pin high, manual pin low: manual reset, CPU and interrupt controller only.
// - Manual reset waits for current bus cycle to end, never aborts it.
// - Manual pin release runs the same sequence using manual vectors.
// - Priority: resets, address errors, interrupts, instruction exceptions.
// - Address errors and interrupts start after preceding instruction finishes.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module exc_reset_unit
	import exc_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               power_on_reset_pin_n,
	input  wire logic               manual_reset_pin_n,
	input  wire logic               watchdog_reset_req,
	input  wire logic               bus_cycle_busy,
	input  wire logic               instr_done,
	input  wire logic               addr_err_req,
	input  wire logic               addr_err_dma,
	input  wire logic               intr_req,
	input  wire logic [VEC_W-1:0]   intr_vec,
	input  wire logic [LEVEL_W-1:0] intr_level,
	input  wire logic               instr_req,
	input  wire logic               instr_slot,
	input  wire logic               instr_trap,
	input  wire logic [VEC_W-1:0]   trap_num,
	input  wire logic [WORD_W-1:0]  status_word,
	input  wire logic [WORD_W-1:0]  instruction_pointer,
	input  wire logic [WORD_W-1:0]  general_reg_fifteen,
	input  wire logic [WORD_W-1:0]  mem_rdata,
	output logic                    mem_rd,
	output logic                    mem_wr,
	output logic      [WORD_W-1:0]  mem_addr,
	output logic      [WORD_W-1:0]  mem_wdata,
	output logic      [WORD_W-1:0]  vector_base_reg,
	output logic      [LEVEL_W-1:0] interrupt_mask_field,
	output logic      [WORD_W-1:0]  new_pointer,
	output logic      [WORD_W-1:0]  new_stack_top,
	output logic                    load_pointer,
	output logic                    load_stack_top,
	output logic                    load_mask,
	output logic                    exc_accept,
	output logic                    cpu_init,
	output logic                    interrupt_ctrl_unit_init,
	output logic                    periph_init,
	output logic                    pin_port_init,
	output logic                    clear_overflow_flag,
	output logic                    cpu_hold
);
	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	logic       por_q;
	logic       man_q;
	logic       wdt_q;
	seq_state_t state_q;
	seq_state_t state_d;
	logic       manual_q;
	logic       from_pin_q;
	exc_kind_t  kind_q;
	logic [VEC_W-1:0]   vec_q;
	logic [LEVEL_W-1:0] level_q;
	logic [WORD_W-1:0]  sp_q;

	// Registered samples of resets, taken on the clock
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			por_q <= 1'b0;
			man_q <= 1'b1;
			wdt_q <= 1'b0;
		end
		else
		begin
			por_q <= power_on_reset_pin_n;
			man_q <= manual_reset_pin_n;
			wdt_q <= watchdog_reset_req;
		end
	end

	// ----------------------------------------
	// Source selection and vectors
	// ----------------------------------------
	logic              any_req;
	exc_kind_t         sel_kind;
	logic [VEC_W-1:0]  sel_vec;
	logic [VEC_W-1:0]  ae_vec;
	logic [VEC_W-1:0]  in_vec;
	logic [VEC_W-1:0]  fetch_vec;
	logic              fetch_reset;
	logic [WORD_W-1:0] table_addr;

	assign ae_vec = addr_err_dma ? VEC_DMA_ADDR : VEC_CPU_ADDR;
	// Trap numbers fold into 32..63; otherwise illegal or slot illegal
	assign in_vec = instr_trap ? (VEC_TRAP_BASE | (trap_num & VEC_TRAP_MASK))
		: (instr_slot ? VEC_SLOT_ILL : VEC_ILLEGAL);

	exc_source_prio u_prio (
		.addr_err_req (addr_err_req),
		.addr_err_vec (ae_vec),
		.intr_req     (intr_req),
		.intr_vec     (intr_vec),
		.instr_req    (instr_req),
		.instr_vec    (in_vec),
		.any_req      (any_req),
		.kind         (sel_kind),
		.vector       (sel_vec)
	);

	// Reset fetches use fixed vectors, others the latched one
	always_comb
	begin
		fetch_reset = 1'b1;
		if (state_q == ST_FETCH_PC)
			fetch_vec = manual_q ? VEC_MAN_PC : VEC_POR_PC;
		else if (state_q == ST_FETCH_SP)
			fetch_vec = manual_q ? VEC_MAN_SP : VEC_POR_SP;
		else
		begin
			fetch_vec   = vec_q;
			fetch_reset = 1'b0;
		end
	end

	exc_vec_addr u_addr (
		.vector          (fetch_vec),
		.is_reset        (fetch_reset),
		.vector_base_reg (vector_base_reg),
		.table_addr      (table_addr)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic por_low;
	logic wdt_hit;
	logic man_low;
	assign por_low = !por_q;
	assign wdt_hit = wdt_q && por_q;
	assign man_low = por_q && !man_q;

	// Next state: resets first, then pending exceptions
	always_comb
	begin
		state_d = state_q;
		if (por_low || wdt_hit)
			state_d = ST_POR_HOLD;
		else
		begin
			case (state_q)
				ST_POR_HOLD:
					state_d = ST_FETCH_PC;
				ST_MAN_WAIT:
					if (!bus_cycle_busy)
						state_d = ST_MAN_HOLD;
				ST_MAN_HOLD:
					if (man_q)
						state_d = ST_FETCH_PC;
				ST_FETCH_PC:
					state_d = ST_FETCH_SP;
				ST_FETCH_SP:
					state_d = ST_RUN;
				ST_PUSH_SR:
					state_d = ST_PUSH_PC;
				ST_PUSH_PC:
					state_d = ST_FETCH_VEC;
				ST_FETCH_VEC:
					state_d = ST_RUN;
				ST_RUN:
					if (any_req && instr_done)
						state_d = ST_PUSH_SR;
				default:
					state_d = ST_POR_HOLD;
			endcase
			if (man_low && state_q != ST_MAN_HOLD && state_q != ST_MAN_WAIT)
				state_d = ST_MAN_WAIT;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			state_q <= ST_POR_HOLD;
		else
			state_q <= state_d;
	end

	// Which reset type owns the vector fetch, and whether from the pin
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			manual_q   <= 1'b0;
			from_pin_q <= 1'b1;
		end
		else if (por_low || wdt_hit)
		begin
			manual_q   <= 1'b0;
			from_pin_q <= por_low;
		end
		else if (state_d == ST_MAN_WAIT)
			manual_q <= 1'b1;
	end

	// Latch the accepted exception
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			kind_q  <= KIND_INSTR;
			vec_q   <= VEC_ILLEGAL;
			level_q <= MASK_RESET;
		end
		else if (state_q == ST_RUN && state_d == ST_PUSH_SR)
		begin
			kind_q  <= sel_kind;
			vec_q   <= sel_vec;
			level_q <= intr_level;
		end
	end

	// Stack pointer walks down for each push
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			sp_q <= VBR_RESET;
		else if (state_q == ST_RUN)
			sp_q <= general_reg_fifteen - STACK_STEP;
		else if (state_q == ST_PUSH_SR)
			sp_q <= sp_q - STACK_STEP;
	end

	// ----------------------------------------
	// Memory access, one per push or fetch state
	// ----------------------------------------
	always_comb
	begin
		mem_rd    = 1'b0;
		mem_wr    = 1'b0;
		mem_addr  = table_addr;
		mem_wdata = status_word;
		case (state_q)
			ST_PUSH_SR:
			begin
				mem_wr   = 1'b1;
				mem_addr = sp_q;
			end
			ST_PUSH_PC:
			begin
				mem_wr    = 1'b1;
				mem_addr  = sp_q;
				mem_wdata = instruction_pointer;
			end
			ST_FETCH_PC, ST_FETCH_SP, ST_FETCH_VEC:
				mem_rd = 1'b1;
			default:
				mem_rd = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Architectural updates
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			vector_base_reg      <= VBR_RESET;
			interrupt_mask_field <= MASK_RESET;
		end
		else if (state_q == ST_POR_HOLD || state_q == ST_MAN_HOLD)
		begin
			vector_base_reg      <= VBR_RESET;
			interrupt_mask_field <= MASK_RESET;
		end
		else if (state_q == ST_PUSH_PC && kind_q == KIND_INTR)
			interrupt_mask_field <= level_q;
	end

	// Loaded values for the core
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			new_pointer    <= VBR_RESET;
			new_stack_top  <= VBR_RESET;
			load_pointer   <= 1'b0;
			load_stack_top <= 1'b0;
			load_mask      <= 1'b0;
		end
		else
		begin
			load_pointer   <= 1'b0;
			load_stack_top <= 1'b0;
			load_mask      <= state_q == ST_PUSH_PC && kind_q == KIND_INTR;
			if (state_q == ST_FETCH_SP)
			begin
				new_stack_top  <= mem_rdata;
				load_pointer   <= 1'b1;
				load_stack_top <= 1'b1;
			end
			else if (state_q == ST_FETCH_VEC)
			begin
				new_pointer    <= mem_rdata;
				new_stack_top  <= sp_q;
				load_pointer   <= 1'b1;
				load_stack_top <= 1'b1;
			end
			if (state_q == ST_FETCH_PC)
				new_pointer <= mem_rdata;
		end
	end

	// ----------------------------------------
	// Init strobes toward the rest of the chip
	// ----------------------------------------
	logic in_reset;
	assign in_reset            = state_q == ST_POR_HOLD || state_q == ST_MAN_HOLD;
	assign cpu_init            = in_reset;
	assign interrupt_ctrl_unit_init           = in_reset;
	assign periph_init         = state_q == ST_POR_HOLD;
	assign pin_port_init       = state_q == ST_POR_HOLD && from_pin_q;
	assign clear_overflow_flag = por_low && wdt_q;
	assign exc_accept          = state_q == ST_RUN && state_d == ST_PUSH_SR;
	assign cpu_hold            = state_q != ST_RUN;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_por_fetch_order: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_POR_HOLD && state_d == ST_FETCH_PC) |=> mem_rd ##1 mem_rd ##1 load_pointer)
		else $error("reset fetch order wrong");
	a_reset_vec_addr: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_FETCH_PC && !manual_q)
		|-> mem_addr == {{(WORD_W-VEC_W-2){1'b0}}, VEC_POR_PC, VEC_SHIFT_ZERO})
		else $error("power-on pointer address wrong");
	a_push_sequence: assert property (@(posedge clk) disable iff (!reset_n)
		exc_accept |=> (mem_wr && mem_wdata == $past(status_word)) ##1 mem_wr ##1 mem_rd)
		else $error("push sequence wrong");
	a_vbr_added: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_FETCH_VEC
		|-> mem_addr == vector_base_reg + {{(WORD_W-VEC_W-2){1'b0}}, vec_q, VEC_SHIFT_ZERO})
		else $error("vector address not based");
	a_mask_keep: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_PUSH_PC && kind_q != KIND_INTR) |=> $stable(interrupt_mask_field))
		else $error("mask changed for non-interrupt");
	a_por_init: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_POR_HOLD |=> vector_base_reg == VBR_RESET && interrupt_mask_field == MASK_RESET)
		else $error("reset init values wrong");
	a_man_bus_wait: assert property (@(posedge clk) disable iff (!reset_n)
		(state_q == ST_MAN_WAIT && bus_cycle_busy && por_q && !wdt_q) |=> state_q == ST_MAN_WAIT)
		else $error("manual reset aborted bus cycle");
	a_man_no_periph: assert property (@(posedge clk) disable iff (!reset_n)
		state_q == ST_MAN_HOLD |-> cpu_init && !periph_init && !pin_port_init)
		else $error("manual reset touched peripherals");
	a_reset_priority: assert property (@(posedge clk) disable iff (!reset_n)
		por_low |=> state_q == ST_POR_HOLD)
		else $error("reset lost priority");
	a_wdt_no_pins: assert property (@(posedge clk) disable iff (!reset_n)
		(wdt_hit && !por_low) |=> !pin_port_init)
		else $error("watchdog reset hit pin registers");

	c_por_seq: cover property (@(posedge clk) state_q == ST_POR_HOLD ##1 state_q == ST_FETCH_PC);
	c_man_seq: cover property (@(posedge clk) state_q == ST_MAN_HOLD ##1 state_q == ST_FETCH_PC);
	c_intr_entry: cover property (@(posedge clk) exc_accept && sel_kind == KIND_INTR);
	c_wdt_reset: cover property (@(posedge clk) wdt_hit);
endmodule
`default_nettype wire

/* File: tb/reset_source_model.sv */
// Reset pins, watchdog request and vector memory facing the exception unit
`timescale 1ns/1ps
`default_nettype none
module reset_source_model
	import exc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              mem_rd,
	input  wire logic [WORD_W-1:0] mem_addr,
	output logic      [WORD_W-1:0] mem_rdata,
	output logic                   power_on_reset_pin_n,
	output logic                   manual_reset_pin_n,
	output logic                   watchdog_reset_req
);
	logic flip_q;

	// Power pin is low from power-up until a scenario lets it go
	initial
	begin
		power_on_reset_pin_n = 1'b0;
		manual_reset_pin_n   = 1'b1;
		watchdog_reset_req   = 1'b0;
		flip_q               = 1'b0;
	end

	// Unselected memory shows a pattern that changes every cycle
	always @(posedge clk)
		flip_q <= ~flip_q;

	// Memory answers in the cycle of the read strobe
	assign mem_rdata = mem_rd ? (mem_addr ^ 32'h5A5A_0000) : {WORD_W{flip_q}};

	// Sets the request lines after an edge and holds them; a low pin stays low at least 20 cycles
	task automatic drive(input logic por_n, input logic man_n, input logic wd, input int cycles);
		int n;
		n = cycles;
		if (!por_n || !man_n)
			n = (cycles < 20) ? 20 : cycles;
		@(posedge clk);
		power_on_reset_pin_n <= por_n;
		manual_reset_pin_n   <= man_n;
		watchdog_reset_req   <= wd;
		repeat (n) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the exception entry and reset sequencing unit
`timescale 1ns/1ps
`default_nettype none
module tb
	import exc_pkg::*;
;
	logic                 clk = 1'b0;
	logic                 reset_n, bus_cycle_busy, instr_done, addr_err_req, addr_err_dma;
	logic                 intr_req, instr_req, instr_slot, instr_trap, mem_rd, mem_wr;
	logic                 power_on_reset_pin_n, manual_reset_pin_n, watchdog_reset_req;
	logic                 load_pointer, load_stack_top, load_mask, exc_accept, cpu_init;
	logic                 interrupt_ctrl_unit_init, periph_init, pin_port_init, clear_overflow_flag, cpu_hold;
	logic [VEC_W-1:0]     intr_vec, trap_num;
	logic [LEVEL_W-1:0]   intr_level, interrupt_mask_field, exp_mask;
	logic [WORD_W-1:0]    status_word, instruction_pointer, general_reg_fifteen, mem_rdata;
	logic [WORD_W-1:0]    mem_addr, mem_wdata, vector_base_reg, new_pointer, new_stack_top;
	int                   fails = 0;
	int                   samples_checked = 0;

	// ----------------------------------------
	// Clock, design and far side
	// ----------------------------------------
	always #12.5 clk = ~clk;

	exc_reset_unit i_dut (.clk, .reset_n, .power_on_reset_pin_n, .manual_reset_pin_n,
		.watchdog_reset_req, .bus_cycle_busy, .instr_done, .addr_err_req, .addr_err_dma,
		.intr_req, .intr_vec, .intr_level, .instr_req, .instr_slot, .instr_trap, .trap_num,
		.status_word, .instruction_pointer, .general_reg_fifteen, .mem_rdata, .mem_rd,
		.mem_wr, .mem_addr, .mem_wdata, .vector_base_reg, .interrupt_mask_field,
		.new_pointer, .new_stack_top, .load_pointer, .load_stack_top, .load_mask,
		.exc_accept, .cpu_init, .interrupt_ctrl_unit_init, .periph_init, .pin_port_init,
		.clear_overflow_flag, .cpu_hold);

	reset_source_model i_partner (.clk, .mem_rd, .mem_addr, .mem_rdata,
		.power_on_reset_pin_n, .manual_reset_pin_n, .watchdog_reset_req);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finish_test();
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp,
		input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// Moves to just after the n-th next edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Bounded wait for a read strobe (0) or an accepted exception (1)
	task automatic wait_for(input int which);
		int k;
		for (k = 0; k < 64; k++)
		begin
			if ((which == 0) ? (mem_rd === 1'b1) : (exc_accept === 1'b1))
				return;
			cyc(1);
		end
		fails++;
		finish_test();
	endtask

	// Initial pointer then stack top fetched from the reset vectors at off
	task automatic fetch_seq(input logic [WORD_W-1:0] off);
		wait_for(0);
		check(mem_addr, off, "first fetch address");
		cyc(1);
		check(mem_rd, 1'b1, "second fetch strobe");
		check(mem_addr, off + 32'h0000_0004, "second fetch address");
		cyc(1);
		check(load_pointer & load_stack_top, 1'b1, "load pulses");
		check(new_pointer, off ^ 32'h5A5A_0000, "start pointer");
		check(new_stack_top, (off + 32'h0000_0004) ^ 32'h5A5A_0000, "stack top");
		check(vector_base_reg, 32'h0000_0000, "base cleared");
		check(interrupt_mask_field, 4'hF, "mask set");
		exp_mask = 4'hF;
		cyc(1);
		check(cpu_hold, 1'b0, "running");
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_por();
		check(cpu_init & interrupt_ctrl_unit_init & periph_init & pin_port_init, 1'b1, "full init");
		i_partner.drive(1'b1, 1'b1, 1'b0, 0);
		#1;
		fetch_seq(32'h0000_0000);
	endtask

	// Manual reset waits for the bus cycle, then spares the peripherals
	task automatic t_manual();
		fork
			i_partner.drive(1'b1, 1'b0, 1'b0, 24);
			begin
				@(posedge clk);
				bus_cycle_busy <= 1'b1;
				cyc(4);
				check(cpu_init, 1'b0, "bus cycle kept");
				@(posedge clk);
				bus_cycle_busy <= 1'b0;
				cyc(4);
				check(cpu_init & interrupt_ctrl_unit_init, 1'b1, "core init");
				check(periph_init | pin_port_init, 1'b0, "peripherals kept");
			end
		join
		i_partner.drive(1'b1, 1'b1, 1'b0, 0);
		#1;
		fetch_seq(32'h0000_0008);
	endtask

	task automatic t_watchdog();
		i_partner.drive(1'b1, 1'b1, 1'b1, 3);
		#1;
		check(periph_init, 1'b1, "watchdog inits peripherals");
		check(pin_port_init, 1'b0, "watchdog spares pins");
		i_partner.drive(1'b1, 1'b1, 1'b0, 0);
		#1;
		fetch_seq(32'h0000_0000);
	endtask

	// Pin and watchdog together, with an interrupt pending that must wait
	task automatic t_coincide();
		// Request rises once the reset samples are low, so only priority can hold it off
		fork
			i_partner.drive(1'b0, 1'b1, 1'b1, 20);
			begin
				repeat (2) @(posedge clk);
				intr_req <= 1'b1;
			end
		join
		#1;
		check(clear_overflow_flag, 1'b1, "overflow flag cleared");
		check(pin_port_init, 1'b1, "pin reset wins");
		check(exc_accept, 1'b0, "reset beats interrupt");
		@(posedge clk);
		intr_req <= 1'b0;
		i_partner.drive(1'b1, 1'b1, 1'b0, 0);
		#1;
		fetch_seq(32'h0000_0000);
	endtask

	// Kind: 0 address error, 1 interrupt, 2 illegal, 3 trap, 4 all three at once
	task automatic t_exc(input int kind, input logic sel, input logic [7:0] num,
		input logic [7:0] vec);
		logic [WORD_W-1:0] r15;
		r15 = 32'h0000_8000 + num;
		@(posedge clk);
		instr_done <= 1'b0;
		addr_err_req <= (kind == 0 || kind == 4);
		addr_err_dma <= sel;
		intr_req <= (kind == 1 || kind == 4);
		intr_vec <= num;
		intr_level <= num[3:0];
		instr_req <= (kind >= 2);
		instr_slot <= sel;
		instr_trap <= (kind == 3);
		trap_num <= num;
		general_reg_fifteen <= r15;
		status_word <= {24'h0, num};
		instruction_pointer <= 32'h0000_4000 + num;
		cyc(3);
		check(exc_accept, 1'b0, "waits for instruction end");
		@(posedge clk);
		instr_done <= 1'b1;
		#1;
		wait_for(1);
		@(posedge clk);
		addr_err_req <= 1'b0;
		intr_req <= 1'b0;
		instr_req <= 1'b0;
		#1;
		check(mem_wr, 1'b1, "status push");
		check(mem_addr, r15 - 32'h0000_0004, "status slot");
		check(mem_wdata, {24'h0, num}, "status value");
		cyc(1);
		check(mem_wr, 1'b1, "pointer push");
		check(mem_addr, r15 - 32'h0000_0008, "pointer slot");
		check(mem_wdata, 32'h0000_4000 + num, "pointer value");
		cyc(1);
		check(mem_rd, 1'b1, "vector read");
		check(mem_addr, {22'h0, vec, 2'h0}, "vector address");
		check(load_mask, kind == 1, "mask load");
		if (kind == 1)
			exp_mask = num[3:0];
		cyc(1);
		check(load_pointer, 1'b1, "jump");
		check(new_pointer, {22'h0, vec, 2'h0} ^ 32'h5A5A_0000, "routine address");
		check(new_stack_top, r15 - 32'h0000_0008, "stack after push");
		check(interrupt_mask_field, exp_mask, "mask value");
		cyc(2);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		reset_n <= 1'b0;
		bus_cycle_busy <= 1'b0;
		instr_done <= 1'b1;
		{addr_err_req, addr_err_dma, intr_req, instr_req, instr_slot, instr_trap} <= 6'h00;
		{intr_vec, trap_num, intr_level} <= 20'h00000;
		{status_word, instruction_pointer, general_reg_fifteen} <= 96'h0;
		exp_mask = 4'hF;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		cyc(20);
		t_por();
		t_manual();
		t_watchdog();
		t_coincide();
		t_exc(0, 1'b0, 8'h11, 8'h09);
		t_exc(0, 1'b1, 8'h12, 8'h0A);
		t_exc(1, 1'b0, 8'h0B, 8'h0B);
		t_exc(1, 1'b0, 8'h0C, 8'h0C);
		t_exc(1, 1'b0, 8'h0E, 8'h0E);
		t_exc(1, 1'b0, 8'h40, 8'h40);
		t_exc(1, 1'b0, 8'h47, 8'h47);
		t_exc(1, 1'b0, 8'h48, 8'h48);
		t_exc(1, 1'b0, 8'hFF, 8'hFF);
		t_exc(2, 1'b0, 8'h13, 8'h04);
		t_exc(2, 1'b1, 8'h14, 8'h06);
		t_exc(3, 1'b0, 8'h00, 8'h20);
		t_exc(3, 1'b0, 8'h1F, 8'h3F);
		t_exc(3, 1'b0, 8'hE5, 8'h25);
		t_exc(4, 1'b0, 8'h4B, 8'h09);
		finish_test();
	end
endmodule
`default_nettype wire
